// ==== hw/hbp_port.sv ====
/*
  Host parallel port of a small peripheral controller: output buffer,
  input buffer and status byte behind chip select, register select and
  active-low strobes. Host pins are sampled through two-stage synchronisers;
  the internal side loads/drains buffers through plain ports.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: Selected read with select low drives output buffer, clears output-full.
// RULE2: Selected read with select high drives the status byte.
// RULE3: Selected write captures host data into the input buffer.
// RULE4: Write sets input-full and raises internal interrupt when enabled.
// RULE5: Write stores select level as command/data flag.
// RULE6: Data lines driven only during a selected read, else released.
// RULE7: Strobes ignored unless chip select is low.
// RULE8: Strobes are active low; transfers only while strobe low.
// RULE9: Host decodes chip and register select from its address bus.
// RULE10: Internal load of output buffer sets output-full.
// RULE11: Internal read of the last byte in the input buffer clears input-full.
// RULE12: Reset clears every status flag.
// RULE13: Status bits: out-full 0, in-full 1, gp 2, cmd 3, user 7..4.
// RULE14: Host strobes synchronised; one update per strobe.
module hbp_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic register_select_line,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_n,
  input wire logic out_load,
  input wire logic [7:0] out_load_data,
  output logic out_load_ready,
  input wire logic in_take,
  output logic [7:0] in_take_data,
  output logic in_take_cmd,
  output logic in_take_valid,
  input wire logic irq_enable,
  output logic input_irq,
  input wire logic gp_clear,
  input wire logic gp_toggle,
  input wire logic cmd_clear,
  input wire logic cmd_toggle,
  input wire logic user_write,
  input wire logic [3:0] user_status_in,
  output logic output_full_flag,
  output logic input_full_flag,
  output logic [7:0] status_out
);
  typedef struct packed {
    logic cs_s1, cs_s2;
    logic rd_s1, rd_s2, rd_d;
    logic wr_s1, wr_s2, wr_d;
    logic sel_s1, sel_s2;
    logic [7:0] di_s1, di_s2;
    logic [7:0] host_output_buffer;
    logic out_full, gp, cmd;
    logic [3:0] user;
    logic [7:0] dout;
    logic oe_n;
    logic irq;
  } hbp_state_t;
  hbp_state_t st, next_st;

  logic [7:0] status;
  logic rd_go, wr_go, rd_fall, wr_fall, rd_cycle;
  logic buf_in_ready, buf_out_valid;
  logic [8:0] buf_out_data;

  // ----------------------------------------------------------------------
  // Decode of synchronised host pins
  // ----------------------------------------------------------------------
  // RULE7 chip select gating
  assign rd_go = !st.cs_s2 && !st.rd_s2;
  // RULE8 active-low strobes
  assign wr_go = !st.cs_s2 && !st.wr_s2;
  // RULE14 one event per strobe fall
  assign rd_fall = rd_go && !st.rd_d;
  assign wr_fall = wr_go && !st.wr_d;
  // RULE13 status byte layout
  assign status = {st.user, st.cmd, st.gp, buf_out_valid, st.out_full};

  // Input buffer queue keeps bytes when the core is slow to drain
  hbp_skid u_skid (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(wr_fall),
    .in_ready(buf_in_ready),
    .in_data({st.sel_s2, st.di_s2}),
    .out_valid(buf_out_valid),
    .out_ready(in_take),
    .out_data(buf_out_data)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.cs_s1 = chip_select_n;
    next_st.cs_s2 = st.cs_s1;
    next_st.rd_s1 = read_n;
    next_st.rd_s2 = st.rd_s1;
    next_st.wr_s1 = write_n;
    next_st.wr_s2 = st.wr_s1;
    next_st.sel_s1 = register_select_line;
    next_st.sel_s2 = st.sel_s1;
    next_st.di_s1 = host_data_in;
    next_st.di_s2 = st.di_s1;
    next_st.rd_d = rd_go;
    next_st.wr_d = wr_go;
    rd_cycle = rd_go;
    // RULE6 drive only during selected read
    next_st.oe_n = !rd_cycle;
    // RULE1 data read path; RULE2 status read path
    next_st.dout = !rd_cycle ? hbp_pkg::BYTE_ZERO :
                   (st.sel_s2 ? status : st.host_output_buffer);
    // RULE10 internal load sets output-full
    if (out_load) begin
      next_st.host_output_buffer = out_load_data;
      next_st.out_full = 1'h1;
    end else if (rd_fall && !st.sel_s2) begin
      // RULE1 host data read clears output-full
      next_st.out_full = 1'h0;
    end
    // RULE3 write data goes to the queue; RULE5 select as command flag
    if (wr_fall) begin
      next_st.cmd = st.sel_s2;
    end else if (cmd_clear) begin
      next_st.cmd = 1'h0;
    end else if (cmd_toggle) begin
      next_st.cmd = !st.cmd;
    end
    if (gp_clear) begin
      next_st.gp = 1'h0;
    end else if (gp_toggle) begin
      next_st.gp = !st.gp;
    end
    if (user_write) begin
      next_st.user = user_status_in;
    end
    // RULE4 interrupt on write; set wins over clear
    if (wr_fall && irq_enable) begin
      next_st.irq = 1'h1;
    end else if (in_take) begin
      next_st.irq = 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // RULE12 reset clears flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
      st.cs_s1 <= 1'h1;
      st.cs_s2 <= 1'h1;
      st.rd_s1 <= 1'h1;
      st.rd_s2 <= 1'h1;
      st.wr_s1 <= 1'h1;
      st.wr_s2 <= 1'h1;
      st.oe_n <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign host_data_out = st.dout;
  assign host_data_oe_n = st.oe_n;
  assign out_load_ready = !st.out_full;
  // RULE11 input-full follows the queue; drained by internal take
  assign input_full_flag = buf_out_valid;
  assign output_full_flag = st.out_full;
  assign in_take_valid = buf_out_valid;
  assign in_take_data = buf_out_data[7:0];
  assign in_take_cmd = buf_out_data[8];
  assign input_irq = st.irq;
  assign status_out = status;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_data_read;
    rd_fall && !st.sel_s2 && !out_load;
  endsequence
  a_read_clears_full: assert property (@(posedge clk) disable iff (!rst_n)
    s_data_read |=> !output_full_flag) else $error("out-full not cleared"); // RULE1
  a_status_read_data: assert property (@(posedge clk) disable iff (!rst_n)
    rd_go && st.sel_s2 |=> host_data_out == $past(status))
    else $error("status not driven"); // RULE2
  a_write_capture: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fall && buf_in_ready && !buf_out_valid |=> in_take_data == $past(st.di_s2))
    else $error("write not captured"); // RULE3
  a_write_sets_full: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fall && buf_in_ready |=> input_full_flag) else $error("in-full not set"); // RULE4
  a_write_irq: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fall && irq_enable |=> input_irq) else $error("irq not raised"); // RULE4
  a_cmd_flag: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fall |=> status_out[hbp_pkg::STS_CMD] == $past(st.sel_s2))
    else $error("cmd flag wrong"); // RULE5
  a_release_bus: assert property (@(posedge clk) disable iff (!rst_n)
    st.cs_s2 |=> host_data_oe_n) else $error("bus driven while unselected"); // RULE6
  a_load_sets_full: assert property (@(posedge clk) disable iff (!rst_n)
    out_load |=> output_full_flag ##0 status_out[hbp_pkg::STS_OUT_FULL])
    else $error("out-full not set"); // RULE10
  a_one_event: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fall |=> !wr_fall) else $error("double write event"); // RULE14
  // Last byte taken with no write behind it leaves the queue empty
  a_take_clears_full: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    in_take && buf_out_valid && buf_in_ready && !wr_fall |=> !input_full_flag)
    else $error("in-full not cleared");
endmodule : hbp_port
`default_nettype wire

// ==== hw/hbp_pkg.sv ====
/*
  Package for the host bus buffer port: status bit positions, reset values,
  input buffer depth. Assumes a single 40 MHz device clock.
*/
package hbp_pkg;
  // ----------------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------------
  localparam int STS_OUT_FULL = 0;
  localparam int STS_IN_FULL = 1;
  localparam int STS_GP = 2;
  localparam int STS_CMD = 3;
  localparam int STS_USER_LO = 4;
  localparam int STS_USER_HI = 7;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] USER_ZERO = 4'h0;
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] CNT_FULL = 2'h2;
endpackage : hbp_pkg

// ==== hw/hbp_skid.sv ====
/*
  Two-entry valid/ready buffer for host-written bytes with their
  command/data mark. Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module hbp_skid (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [8:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [8:0] out_data
);
  typedef struct packed {
    logic [8:0] e0;
    logic [8:0] e1;
    logic [1:0] cnt;
  } hbp_skid_t;
  hbp_skid_t st, next_st;

  // ----------------------------------------------------------------------
  // Queue control
  // ----------------------------------------------------------------------
  assign in_ready = (st.cnt != hbp_pkg::CNT_FULL);
  assign out_valid = (st.cnt != hbp_pkg::CNT_ZERO);
  assign out_data = st.e0;

  // Pop shifts entry one down; push lands behind the survivors
  always_comb begin
    logic pop;
    logic push;
    pop = out_valid && out_ready;
    push = in_valid && in_ready;
    next_st = st;
    if (pop) begin
      next_st.e0 = st.e1;
    end
    case ({push, pop})
      2'h2: next_st.cnt = st.cnt + hbp_pkg::CNT_ONE;
      2'h1: next_st.cnt = st.cnt - hbp_pkg::CNT_ONE;
      default: next_st.cnt = st.cnt;
    endcase
    if (push) begin
      if (next_st.cnt == hbp_pkg::CNT_ONE && !(pop && st.cnt == hbp_pkg::CNT_ONE))
        next_st.e0 = in_data;
      else if (pop && st.cnt == hbp_pkg::CNT_ONE)
        next_st.e0 = in_data;
      else
        next_st.e1 = in_data;
    end
  end

  // Register the whole state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : hbp_skid
`default_nettype wire

// ==== testbench/hbp_host.sv ====
/*
  Host master model for the host bus buffer port: strobes, selects, data.
  Assumes the bench merges its data drive with the port's split pins.
*/
`timescale 1ns/1ps
`default_nettype none
module hbp_host (
  input wire logic clk,
  input wire logic [7:0] din,
  input wire logic oe_n,
  output logic cs_n,
  output logic sel,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] dq
);
  logic [7:0] got;
  logic got_oe;
  // Idle bus: all strobes high, lines not held at a stale value
  initial begin
    cs_n = 1'h1;
    sel = 1'h0;
    rd_n = 1'h1;
    wr_n = 1'h1;
    dq = 8'hFF;
  end
  // One host access, called 2 ns after a rising edge
  // active-low strobe, selects held for five clocks
  task automatic cycle(input logic c, input logic a, input logic w,
    input logic [7:0] v);
    cs_n = c;
    sel = a;
    dq = w ? v : ~dq;
    if (w) wr_n = 1'h0;
    else rd_n = 1'h0;
    // Sample off the edge, a cycle before release, so no flop races it
    repeat (4) @(posedge clk);
    #2;
    got = din;
    got_oe = oe_n;
    @(posedge clk);
    #2;
    rd_n = 1'h1;
    wr_n = 1'h1;
    cs_n = 1'h1;
    dq = ~dq; // Released lines must not keep the old value
    repeat (4) @(posedge clk);
    #2;
  endtask : cycle
endmodule : hbp_host
`default_nettype wire

// ==== testbench/tb.sv ====
/*
  Self-checking bench for hbp_port, one task per scenario.
  Assumes a 40 MHz clock and the host model in hbp_host.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch t=%0t got %0h want %0h", $time, (a), (b)); end end
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic out_load = 1'b0, in_take = 1'b0, irq_enable = 1'b0;
  logic gp_clear = 1'b0, gp_toggle = 1'b0, cmd_clear = 1'b0;
  logic cmd_toggle = 1'b0, user_write = 1'b0;
  logic [7:0] out_load_data = 8'h00;
  logic [3:0] user_status_in = 4'h0;
  wire logic cs_n, sel, rd_n, wr_n, oe_n, olr, ofull, ifull, irq;
  wire logic tv, tcmd;
  wire logic [7:0] dq, dout, bus, td, sts;
  int err_total = 0, tests_run = 0, cycles = 0;
  // Wire level: device wins only while it enables its drivers
  assign bus = oe_n ? dq : dout;
  always #12.5 clk = ~clk;
  hbp_host host (.clk(clk), .din(bus), .oe_n(oe_n), .cs_n(cs_n),
    .sel(sel), .rd_n(rd_n), .wr_n(wr_n), .dq(dq));
  hbp_port uut (.clk(clk), .rst_n(rst_n), .chip_select_n(cs_n),
    .register_select_line(sel), .read_n(rd_n), .write_n(wr_n),
    .host_data_in(bus), .host_data_out(dout), .host_data_oe_n(oe_n),
    .out_load(out_load), .out_load_data(out_load_data),
    .out_load_ready(olr), .in_take(in_take), .in_take_data(td),
    .in_take_cmd(tcmd), .in_take_valid(tv), .irq_enable(irq_enable),
    .input_irq(irq), .gp_clear(gp_clear), .gp_toggle(gp_toggle),
    .cmd_clear(cmd_clear), .cmd_toggle(cmd_toggle),
    .user_write(user_write), .user_status_in(user_status_in),
    .output_full_flag(ofull), .input_full_flag(ifull), .status_out(sts));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // Core takes one byte; one-cycle pulse
  task automatic take();
    in_take = 1'b1;
    tick(1);
    in_take = 1'b0;
    tick(1);
  endtask : take
  // Hang guard: whole run is well under 1000 clocks
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_write();
    irq_enable = 1'b1;
    host.cycle(1'b0, 1'b0, 1'b1, 8'hA5);
    `CHK(td, 8'hA5)
    `CHK(tcmd, 1'b0)
    `CHK(irq, 1'b1)
    `CHK(sts[3:0], 4'h2)
    take();
    `CHK(ifull, 1'b0)
    `CHK(irq, 1'b0)
    irq_enable = 1'b0;
    host.cycle(1'b0, 1'b1, 1'b1, 8'h3C);
    `CHK({irq, ifull, tcmd, sts[3]}, 4'h7)
    take();
    host.cycle(1'b1, 1'b0, 1'b1, 8'h77);
    `CHK(ifull, 1'b0)
  endtask : t_write
  task automatic t_read();
    out_load_data = 8'h5A;
    out_load = 1'b1;
    tick(1);
    out_load = 1'b0;
    tick(1);
    `CHK({ofull, olr}, 2'h2)
    host.cycle(1'b1, 1'b0, 1'b0, 8'h00);
    `CHK({host.got_oe, ofull}, 2'h3)
    host.cycle(1'b0, 1'b1, 1'b0, 8'h00);
    `CHK(host.got, 8'h09)
    host.cycle(1'b0, 1'b0, 1'b0, 8'h00);
    `CHK(host.got, 8'h5A)
    `CHK({host.got_oe, ofull, oe_n}, 3'h1)
  endtask : t_read
  // Third write while two wait is dropped by the buffer
  task automatic t_buf();
    host.cycle(1'b0, 1'b0, 1'b1, 8'h11);
    host.cycle(1'b0, 1'b0, 1'b1, 8'h22);
    host.cycle(1'b0, 1'b0, 1'b1, 8'h33);
    `CHK(td, 8'h11)
    take();
    `CHK(td, 8'h22)
    take();
    `CHK({tv, ifull}, 2'h0)
  endtask : t_buf
  task automatic t_flags();
    {cmd_toggle, gp_toggle, user_write} = 3'h7;
    user_status_in = 4'hC;
    tick(1);
    {cmd_toggle, gp_toggle, user_write} = 3'h0;
    tick(1);
    `CHK(sts, 8'hCC)
    {cmd_clear, gp_clear} = 2'h3;
    tick(1);
    {cmd_clear, gp_clear} = 2'h0;
    tick(1);
    `CHK(sts, 8'hC0)
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    `CHK({sts, oe_n}, 9'h001)
  endtask : t_flags
  initial begin
    tick(6);
    rst_n = 1'b1;
    `CHK({sts, oe_n}, 9'h001)
    tick(3);
    t_write();
    t_read();
    t_buf();
    t_flags();
    finish_test();
  end
endmodule : tb
`default_nettype wire
